// ==== common/cev_pkg.sv ====
package cev_pkg;
  // ----------------------------------------
  // Event kinds
  // ----------------------------------------
  localparam int NUM_KINDS = 18;
  localparam int KIND_W = 5;
  localparam logic [KIND_W-1:0] EV_CAPTURE_BEGIN = 5'h00;
  localparam logic [KIND_W-1:0] EV_CAPTURE_FINISH = 5'h01;
  localparam logic [KIND_W-1:0] EV_IMAGE_BEGIN = 5'h02;
  localparam logic [KIND_W-1:0] EV_IMAGE_FINISH = 5'h03;
  localparam logic [KIND_W-1:0] EV_ACCEPTED_TRIG = 5'h04;
  localparam logic [KIND_W-1:0] EV_REJECTED_TRIG = 5'h05;
  localparam logic [KIND_W-1:0] EV_DROPPED_IMAGE = 5'h06;
  localparam logic [KIND_W-1:0] EV_REJECTED_ROW = 5'h07;
  localparam logic [KIND_W-1:0] EV_DEFERRED_ROW = 5'h08;
  localparam logic [KIND_W-1:0] EV_PIN_CHANGE_BASE = 5'h09;
  localparam logic [KIND_W-1:0] EV_PULSE_BASE = 5'h0d;
  localparam logic [KIND_W-1:0] EV_BACKLOG = 5'h11;
  localparam int NUM_IN_PINS = 4;
  localparam int NUM_PULSE_PINS = 4;

  // ----------------------------------------
  // Settings
  // ----------------------------------------
  typedef enum logic [1:0] {
    CEV_DLV_OFF = 2'h0,
    CEV_DLV_ON = 2'h1,
    CEV_DLV_LEGACY = 2'h2
  } cev_delivery_t;

  typedef enum logic [1:0] {
    CEV_EDGE_RISE = 2'h0,
    CEV_EDGE_FALL = 2'h1,
    CEV_EDGE_ANY = 2'h2
  } cev_edge_t;

  // ----------------------------------------
  // Widths and reset values
  // ----------------------------------------
  localparam int TIME_W = 64;
  localparam int TALLY_W = 32;
  localparam logic [NUM_KINDS-1:0] ENABLE_RST = 18'h0_0000;
  localparam logic [1:0] EDGE_RST = 2'h0;
  localparam logic [TIME_W-1:0] TIME_RST = 64'h0000_0000_0000_0000;

  typedef struct packed {
    logic [KIND_W-1:0] kind;
    logic [TIME_W-1:0] stamp;
  } cev_msg_t;
endpackage

// ==== sim/cev_checker.sv ====
`timescale 1ns/1ps
// ----
// Port rules
// ----
module cev_checker
  import cev_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [KIND_W-1:0] event_kind_pick,
  input wire cev_delivery_t event_delivery_setting,
  input wire logic delivery_write,
  input wire cev_delivery_t delivery_readout,
  input wire logic [TIME_W-1:0] time_counter_readout,
  input wire logic time_clear_cmd,
  input wire logic frame_trigger,
  input wire logic row_trigger,
  input wire logic trigger_allowed,
  input wire logic row_trigger_deferred,
  input wire logic frame_acq_start,
  input wire logic row_acq_start,
  input wire logic msg_valid,
  input wire logic msg_ready,
  input wire cev_msg_t msg_data,
  input wire logic queue_overflow
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  property p_hold; msg_valid && !msg_ready |=> msg_valid && $stable(msg_data); endproperty
  a_hold: assert property (p_hold) else $error("message changed while stalled");
  property p_facc; frame_trigger && trigger_allowed |-> frame_acq_start; endproperty
  a_facc: assert property (p_facc) else $error("allowed frame trigger not taken");
  property p_frej; frame_trigger && !trigger_allowed |-> !frame_acq_start; endproperty
  a_frej: assert property (p_frej) else $error("frame trigger taken when not allowed");
  property p_rrej; row_trigger && !trigger_allowed && !row_trigger_deferred |-> !row_acq_start; endproperty
  a_rrej: assert property (p_rrej) else $error("rejected row trigger started capture");
  property p_rdef; row_trigger && !trigger_allowed && row_trigger_deferred |-> row_acq_start; endproperty
  a_rdef: assert property (p_rdef) else $error("deferred row trigger not taken");
  property p_time; !time_clear_cmd |=> time_counter_readout == $past(time_counter_readout) + 1; endproperty
  a_time: assert property (p_time) else $error("time counter did not step");
  property p_tclr; time_clear_cmd |=> time_counter_readout == 64'h0000_0000_0000_0000; endproperty
  a_tclr: assert property (p_tclr) else $error("time counter not cleared");
  property p_ovf; queue_overflow |-> delivery_readout == CEV_DLV_OFF; endproperty
  a_ovf: assert property (p_ovf) else $error("kind still enabled after overflow");
  property p_wr;
    delivery_write && event_kind_pick < 5'h12 ##1 $stable(event_kind_pick) && !queue_overflow
      |-> delivery_readout == $past(event_delivery_setting);
  endproperty
  a_wr: assert property (p_wr) else $error("setting not applied to picked kind");
endmodule
bind cev_event_ctrl cev_checker u_cev_checker (.*);

// ==== sim/cev_event_ctrl_bench.sv ====
`timescale 1ns/1ps
// ----
// Bench
// ----
module cev_event_ctrl_bench;
  import cev_pkg::*;
  logic core_clk = 1'b0, sys_rst = 1'b1, delivery_write = 1'b0, count_clear_cmd = 1'b0;
  logic time_clear_cmd = 1'b0, trigger_allowed = 1'b0, row_trigger_deferred = 1'b0, stall = 1'b0;
  logic capture_begin, capture_finish, exposure_delay_begin, active_frame_end, frame_trigger;
  logic row_trigger, image_discarded, frame_acq_start, row_acq_start, msg_valid, msg_ready;
  logic queue_overflow, ovf_seen = 1'b0;
  logic [3:0] io_pin_level = 4'h0, pulse_begin;
  logic [10:0] pul = 11'h000;
  logic [KIND_W-1:0] event_kind_pick = 5'h00, count_kind_pick = 5'h00;
  cev_delivery_t event_delivery_setting = CEV_DLV_OFF, delivery_readout;
  cev_edge_t line_edge_sensitivity = CEV_EDGE_RISE;
  logic [TALLY_W-1:0] occurrence_tally;
  logic [TIME_W-1:0] time_counter_readout;
  cev_msg_t msg_data;
  int n_errors = 0, num_checks = 0;
  // Rows: pulse bit, allowed, deferred, expected kind
  logic [10:0] rows [13] = '{11'h040, 11'h0c1, 11'h142, 11'h1c3, 11'h244, 11'h205, 11'h346,
    11'h287, 11'h2a8, 11'h3cd, 11'h44e, 11'h4cf, 11'h550};
  assign {pulse_begin, image_discarded, row_trigger, frame_trigger, active_frame_end,
    exposure_delay_begin, capture_finish, capture_begin} = pul;
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (queue_overflow === 1'b1) ovf_seen <= 1'b1;
  cev_event_ctrl #(.QUEUE_DEPTH(4)) u_cev_event_ctrl (.*);
  cev_host_model u_cev_host_model (.*);
  task automatic chk(input logic [68:0] got, input logic [68:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic dlv(input logic [4:0] k, input cev_delivery_t s);
    @(posedge core_clk);
    event_kind_pick <= k;
    event_delivery_setting <= s;
    delivery_write <= 1'b1;
    @(posedge core_clk);
    delivery_write <= 1'b0;
  endtask
  task automatic pop(output cev_msg_t m);
    int i;
    for (i = 0; i < 50 && u_cev_host_model.got.size() == 0; i++) @(posedge core_clk);
    if (i == 50) begin
      n_errors++;
      conclude();
    end else begin
      m = u_cev_host_model.got.pop_front();
    end
  endtask
  initial begin
    cev_msg_t m;
    logic [10:0] r;
    tick(12);
    chk(time_counter_readout, 0);
    chk(msg_valid, 0);
    chk(delivery_readout, CEV_DLV_OFF);
    sys_rst <= 1'b0;
    foreach (rows[j]) begin
      r = rows[j];
      dlv(r[4:0], j[0] ? CEV_DLV_LEGACY : CEV_DLV_ON);
      @(posedge core_clk);
      pul <= 11'h001 << r[10:7];
      trigger_allowed <= r[6];
      row_trigger_deferred <= r[5];
      @(posedge core_clk);
      pul <= 11'h000;
      pop(m);
      chk(m.kind, r[4:0]);
      count_kind_pick <= r[4:0];
      tick(2);
      chk(occurrence_tally, 1);
      dlv(r[4:0], CEV_DLV_OFF);
    end
    count_kind_pick <= EV_CAPTURE_BEGIN;
    pul <= 11'h001;
    tick(1);
    pul <= 11'h000;
    tick(6);
    chk(u_cev_host_model.got.size(), 0);
    chk(occurrence_tally, 2);
    for (int i = 0; i < 4; i++) begin
      dlv(EV_PIN_CHANGE_BASE + 5'(i), CEV_DLV_ON);
      line_edge_sensitivity <= cev_edge_t'(i % 3);
      io_pin_level[i] <= 1'b1;
      tick(8);
      io_pin_level[i] <= 1'b0;
      tick(8);
      chk(u_cev_host_model.got.size(), i == 2 ? 2 : 1);
      while (u_cev_host_model.got.size() > 0) begin
        pop(m);
        chk(m.kind, EV_PIN_CHANGE_BASE + 5'(i));
      end
      dlv(EV_PIN_CHANGE_BASE + 5'(i), CEV_DLV_OFF);
    end
    stall <= 1'b1;
    dlv(EV_CAPTURE_BEGIN, CEV_DLV_ON);
    @(posedge core_clk);
    pul <= 11'h001;
    tick(6);
    pul <= 11'h000;
    tick(3);
    chk(ovf_seen, 1);
    chk(delivery_readout, CEV_DLV_OFF);
    stall <= 1'b0;
    tick(20);
    chk(u_cev_host_model.got.size(), 4);
    chk(u_cev_host_model.got[$].kind, EV_BACKLOG);
    chk(occurrence_tally, 8);
    dlv(EV_CAPTURE_BEGIN, CEV_DLV_ON);
    count_clear_cmd <= 1'b1;
    time_clear_cmd <= 1'b1;
    tick(1);
    count_clear_cmd <= 1'b0;
    time_clear_cmd <= 1'b0;
    chk(delivery_readout, CEV_DLV_ON);
    tick(2);
    chk(occurrence_tally, 0);
    conclude();
  end
endmodule

// ==== sim/cev_host_model.sv ====
`timescale 1ns/1ps
// ----
// Host event reader
// ----
module cev_host_model
  import cev_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic stall,
  input wire logic msg_valid,
  input wire cev_msg_t msg_data,
  output logic msg_ready
);
  cev_msg_t got[$];
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      msg_ready <= 1'b0;
    end else begin
      msg_ready <= ~stall;
    end
  end
  always @(posedge core_clk) if (!sys_rst && msg_valid && msg_ready) got.push_back(msg_data);
endmodule

// ==== src/cev_edge_sync.sv ====
`timescale 1ns/1ps
module cev_edge_sync
  import cev_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic pin_in,
  input wire cev_edge_t edge_sel,
  output logic edge_hit
);
  // ----------------------------------------
  // Two-stage synchroniser and edge detect
  // ----------------------------------------
  logic meta_ff;
  logic sync_ff;
  logic last_ff;
  logic rise;
  logic fall;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign rise = sync_ff & ~last_ff;
  assign fall = ~sync_ff & last_ff;

  always_comb begin
    unique case (edge_sel)
      CEV_EDGE_RISE: edge_hit = rise;
      CEV_EDGE_FALL: edge_hit = fall;
      CEV_EDGE_ANY: edge_hit = rise | fall;
      default: edge_hit = 1'b0;
    endcase
  end
endmodule

// ==== src/cev_event_ctrl.sv ====
`timescale 1ns/1ps
module cev_event_ctrl
  import cev_pkg::*;
#(
  parameter int QUEUE_DEPTH = 8
)
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [KIND_W-1:0] event_kind_pick,
  input wire cev_delivery_t event_delivery_setting,
  input wire logic delivery_write,
  output cev_delivery_t delivery_readout,
  input wire cev_edge_t line_edge_sensitivity,
  input wire logic [KIND_W-1:0] count_kind_pick,
  input wire logic count_clear_cmd,
  output logic [TALLY_W-1:0] occurrence_tally,
  output logic [TIME_W-1:0] time_counter_readout,
  input wire logic time_clear_cmd,
  input wire logic capture_begin,
  input wire logic capture_finish,
  input wire logic exposure_delay_begin,
  input wire logic active_frame_end,
  input wire logic frame_trigger,
  input wire logic row_trigger,
  input wire logic trigger_allowed,
  input wire logic row_trigger_deferred,
  input wire logic image_discarded,
  input wire logic [NUM_IN_PINS-1:0] io_pin_level,
  input wire logic [NUM_PULSE_PINS-1:0] pulse_begin,
  output logic frame_acq_start,
  output logic row_acq_start,
  output logic msg_valid,
  input wire logic msg_ready,
  output cev_msg_t msg_data,
  output logic queue_overflow
);
  initial begin
    if (QUEUE_DEPTH < 2 || QUEUE_DEPTH > 256) begin
      $error("QUEUE_DEPTH out of range");
    end
    if ((QUEUE_DEPTH & (QUEUE_DEPTH - 1)) != 0) begin
      $error("QUEUE_DEPTH must be a power of two");
    end
  end

  localparam int PTR_W = $clog2(QUEUE_DEPTH);
  localparam int CMP_W = (PTR_W + 1 > 6) ? PTR_W + 1 : 6;

  // ----------------------------------------
  // Event sources
  // ----------------------------------------
  logic [NUM_KINDS-1:0] raw_ev;
  logic [NUM_IN_PINS-1:0] pin_hit;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN_PINS; gi++) begin : g_pin
      cev_edge_sync u_sync (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .pin_in(io_pin_level[gi]),
        .edge_sel(line_edge_sensitivity),
        .edge_hit(pin_hit[gi])
      );
    end
  endgenerate

  logic overflow_now;

  always_comb begin
    raw_ev = '0;
    raw_ev[EV_CAPTURE_BEGIN] = capture_begin;
    raw_ev[EV_CAPTURE_FINISH] = capture_finish;
    raw_ev[EV_IMAGE_BEGIN] = exposure_delay_begin;
    raw_ev[EV_IMAGE_FINISH] = active_frame_end;
    raw_ev[EV_ACCEPTED_TRIG] = frame_trigger & trigger_allowed;
    raw_ev[EV_REJECTED_TRIG] = frame_trigger & ~trigger_allowed;
    raw_ev[EV_DROPPED_IMAGE] = image_discarded;
    raw_ev[EV_REJECTED_ROW] = row_trigger & ~trigger_allowed & ~row_trigger_deferred;
    raw_ev[EV_DEFERRED_ROW] = row_trigger & ~trigger_allowed & row_trigger_deferred;
    for (int i = 0; i < NUM_IN_PINS; i++) begin
      raw_ev[EV_PIN_CHANGE_BASE + i] = pin_hit[i];
    end
    for (int i = 0; i < NUM_PULSE_PINS; i++) begin
      raw_ev[EV_PULSE_BASE + i] = pulse_begin[i];
    end
    raw_ev[EV_BACKLOG] = overflow_now;
  end

  assign frame_acq_start = frame_trigger & trigger_allowed;
  assign row_acq_start = row_trigger & (trigger_allowed | row_trigger_deferred);

  // ----------------------------------------
  // Delivery settings
  // ----------------------------------------
  logic [NUM_KINDS-1:0] enable_ff;
  logic [NUM_KINDS-1:0] legacy_ff;
  logic [NUM_KINDS-1:0] fire;

  assign fire = raw_ev & (enable_ff | (NUM_KINDS'(overflow_now) << EV_BACKLOG));

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      enable_ff <= ENABLE_RST;
      legacy_ff <= ENABLE_RST;
    end else if (overflow_now) begin
      enable_ff <= ENABLE_RST;
    end else if (delivery_write && event_kind_pick < KIND_W'(NUM_KINDS)) begin
      enable_ff[event_kind_pick] <= (event_delivery_setting != CEV_DLV_OFF);
      legacy_ff[event_kind_pick] <= (event_delivery_setting == CEV_DLV_LEGACY);
    end
  end

  always_comb begin
    delivery_readout = CEV_DLV_OFF;
    if (event_kind_pick < KIND_W'(NUM_KINDS) && enable_ff[event_kind_pick]) begin
      delivery_readout = legacy_ff[event_kind_pick] ? CEV_DLV_LEGACY : CEV_DLV_ON;
    end
  end

  // ----------------------------------------
  // Time counter
  // ----------------------------------------
  logic [TIME_W-1:0] time_ff;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      time_ff <= TIME_RST;
    end else if (time_clear_cmd) begin
      time_ff <= TIME_RST;
    end else begin
      time_ff <= time_ff + 64'h0000_0000_0000_0001;
    end
  end

  assign time_counter_readout = time_ff;

  // ----------------------------------------
  // Occurrence tallies
  // ----------------------------------------
  logic [TALLY_W-1:0] tally_ff [NUM_KINDS];

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_KINDS; i++) begin
        tally_ff[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_KINDS; i++) begin
        if (raw_ev[i]) begin
          tally_ff[i] <= tally_ff[i] + 32'h0000_0001;
        end else if (count_clear_cmd && count_kind_pick == KIND_W'(i)) begin
          tally_ff[i] <= '0;
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      occurrence_tally <= '0;
    end else if (count_kind_pick < KIND_W'(NUM_KINDS)) begin
      occurrence_tally <= tally_ff[count_kind_pick];
    end else begin
      occurrence_tally <= '0;
    end
  end

  // ----------------------------------------
  // Message queue, one slot per event
  // ----------------------------------------
  cev_msg_t queue_mem [QUEUE_DEPTH];
  logic [PTR_W:0] wr_ptr_ff;
  logic [PTR_W:0] rd_ptr_ff;
  logic [PTR_W:0] used;
  logic [PTR_W:0] fire_cnt;
  logic [PTR_W:0] space;
  logic [PTR_W:0] slot_off [NUM_KINDS];
  logic pop;

  assign used = wr_ptr_ff - rd_ptr_ff;
  assign pop = msg_valid & msg_ready;
  assign space = (PTR_W+1)'(QUEUE_DEPTH) - used;

  logic [5:0] cnt_pend;
  always_comb begin
    cnt_pend = '0;
    for (int i = 0; i < NUM_KINDS; i++) begin
      if (i != EV_BACKLOG) begin
        cnt_pend = cnt_pend + {5'h00, raw_ev[i] & enable_ff[i]};
      end
    end
  end

  // Overflow when enabled events would take the last slot, kept for the backlog event
  assign overflow_now = (cnt_pend != 6'h00) && (CMP_W'(cnt_pend) >= CMP_W'(space));

  // Slot offset of each firing kind, in increasing kind order
  always_comb begin
    fire_cnt = '0;
    for (int i = 0; i < NUM_KINDS; i++) begin
      slot_off[i] = fire_cnt;
      fire_cnt = fire_cnt + (PTR_W+1)'(fire[i]);
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_ff <= '0;
    end else if (overflow_now) begin
      if (space != '0) begin
        wr_ptr_ff <= wr_ptr_ff + (PTR_W+1)'(1);
      end
    end else begin
      wr_ptr_ff <= wr_ptr_ff + fire_cnt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (overflow_now) begin
      if (space != '0) begin
        queue_mem[wr_ptr_ff[PTR_W-1:0]] <= '{kind: EV_BACKLOG, stamp: time_ff};
      end
    end else begin
      for (int i = 0; i < NUM_KINDS; i++) begin
        if (fire[i]) begin
          queue_mem[PTR_W'(wr_ptr_ff + slot_off[i])] <= '{kind: KIND_W'(i), stamp: time_ff};
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_ptr_ff <= '0;
    end else if (pop) begin
      rd_ptr_ff <= rd_ptr_ff + (PTR_W+1)'(1);
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      queue_overflow <= 1'b0;
    end else begin
      queue_overflow <= overflow_now;
    end
  end

  assign msg_valid = (used != '0);
  assign msg_data = queue_mem[rd_ptr_ff[PTR_W-1:0]];
endmodule
